/* File: core/conv_ctrl_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH

`define OFF_REF_SEL      4'h0
`define OFF_IN_SEL       4'h1
`define OFF_COMMAND      4'h2
`define OFF_FLAGS        4'h3
`define OFF_IRQ_MASK     4'h4
`define OFF_RESULT_LO    4'h5
`define OFF_RESULT_HI    4'h6
`define OFF_DAC_CTRL     4'h7
`define OFF_DAC_DATA     4'h8
`define OFF_CMP_CTRL     4'h9
`define OFF_STATUS       4'ha

`define REF_ADC_LSB      4
`define REF_ADC_MSB      6
`define REF_DAC_LSB      0
`define REF_DAC_MSB      2
`define REF_RW_MASK      8'h77
`define REF_RESET        8'h00
`define REF_CODE_MAX     3'h4

`define IN_SEL_MASK      8'h1f
`define IN_SEL_RESET     8'h00
`define IN_SEL_EXTERNAL_INPUT_ELEVEN     5'h0b
`define IN_SEL_DAC       5'h1c
`define IN_SEL_INTERNAL_REFERENCE_INPUT    5'h1d
`define IN_SEL_TEMP      5'h1e
`define IN_SEL_GND       5'h1f

`define CMD_START_BIT    0
`define FLAG_RESULT_READY_FLAG_BIT  0
`define FLAG_DACUPD_BIT  1
`define FLAG_CMPCHG_BIT  2
`define DAC_ENABLE_BIT   0
`define CMP_NEG_DAC_BIT  0

`define CONV_TIME_NS     1000
`define CLK_PERIOD_NS    50

`endif

/* File: core/conv_ctrl_pkg.sv */
// types shared by the converter control block
package conv_ctrl_pkg;

  typedef enum logic [2:0] {
    ADC_IDLE = 3'b001,
    ADC_BUSY = 3'b010,
    ADC_DONE = 3'b100
  } adc_state_t;

  typedef struct packed {
    logic [2:0] adc_ref;
    logic [2:0] dac_ref;
  } ref_sel_t;

  typedef struct packed {
    logic [4:0] source;
    logic       start;
  } adc_req_t;

  typedef struct packed {
    logic [9:0] value;
    logic       valid;
  } adc_res_t;

endpackage

/* File: core/adc_sequencer.sv */
// adc conversion sequencer: latches source, times conversion, captures result
`timescale 1ns/10ps
`include "conv_ctrl_regs.svh"
module adc_sequencer
  import conv_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = 20,
  parameter int RES_W       = 10
) (
  // clock, reset, enable
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // request and analog sample
  input  wire adc_req_t         req_i,
  input  wire logic [RES_W-1:0] sample_i,
  // outputs
  output logic                  busy_o,
  output logic [4:0]            source_o,
  output adc_res_t              res_o
);

  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535 || RES_W != 10) begin : g_bad_param
    $error("adc_sequencer: bad parameter");
  end

  localparam logic [15:0] LAST = 16'(CONV_CYCLES - 1);

  adc_state_t  state_r;
  logic [15:0] cnt_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_r <= ADC_IDLE;
      cnt_r   <= 16'h0000;
    end else if (clk_en_i) begin
      case (state_r)
        ADC_IDLE: if (req_i.start) begin
          state_r <= ADC_BUSY;
          cnt_r   <= 16'h0000;
        end
        ADC_BUSY: if (cnt_r == LAST) state_r <= ADC_DONE;
          else cnt_r <= cnt_r + 16'h0001;
        ADC_DONE: state_r <= ADC_IDLE;
        default:  state_r <= ADC_IDLE;
      endcase
    end
  end

  // source held for the whole conversion
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) source_o <= 5'h00;
    else if (clk_en_i && state_r != ADC_BUSY) source_o <= req_i.source;
  end

  // result stored in the same edge the valid pulse rises
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) res_o <= '0;
    else if (clk_en_i) begin
      res_o.valid <= (state_r == ADC_BUSY) && (cnt_r == LAST);
      if ((state_r == ADC_BUSY) && (cnt_r == LAST)) res_o.value <= sample_i;
    end
  end

  assign busy_o = (state_r != ADC_IDLE);

  property p_src_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == ADC_BUSY) && $past(state_r == ADC_BUSY) |-> $stable(source_o);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("source changed mid conversion");

endmodule

/* File: core/dac_comparator.sv */
// dac level holder and comparator output logic
`timescale 1ns/10ps
module dac_comparator (
  // clock, reset, enable
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_en_i,
  // control
  input  wire logic       dac_en_i,
  input  wire logic       data_wr_i,
  input  wire logic [7:0] data_i,
  input  wire logic       neg_dac_i,
  input  wire logic [7:0] neg_pin_level_i,
  input  wire logic [7:0] pos_level_i,
  // outputs
  output logic [7:0]      level_o,
  output logic            update_o,
  output logic            cmp_o
);

  logic [7:0] neg_level;

  // conversion on each data write while enabled, held until the next
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      level_o  <= 8'h00;
      update_o <= 1'b0;
    end else if (clk_en_i) begin
      update_o <= dac_en_i && data_wr_i;
      if (dac_en_i && data_wr_i) level_o <= data_i;
    end
  end

  assign neg_level = neg_dac_i ? level_o : neg_pin_level_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) cmp_o <= 1'b0;
    else if (clk_en_i) cmp_o <= (pos_level_i > neg_level);
  end

  property p_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && !$past(data_wr_i) && $past(clk_en_i) |-> $stable(level_o);
  endproperty
  a_hold: assert property (p_hold) else $error("dac level moved without write");

endmodule

/* File: core/converter_ref_and_input_control.sv */
// register file and top level of the converter reference and input control
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "conv_ctrl_regs.svh"
module converter_ref_and_input_control
  import conv_ctrl_pkg::*;
#(
  parameter int RES_W = 10
) (
  // clock, reset, enable
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // register port
  input  wire logic [3:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic [7:0]            rdata_o,
  // analog side (asynchronous digitised levels)
  input  wire logic [RES_W-1:0] adc_sample_i,
  input  wire logic [7:0]       cmp_pos_level_i,
  input  wire logic [7:0]       cmp_neg_pin_level_i,
  // outputs to analog cores
  output logic [2:0]            adc_ref_sel_o,
  output logic [2:0]            dac_ref_sel_o,
  output logic [4:0]            adc_source_o,
  output logic                  adc_busy_o,
  output logic [7:0]            dac_level_o,
  output logic                  cmp_o,
  output logic                  irq_o
);

  localparam int CONV_CYCLES = (`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  if (RES_W != 10) begin : g_bad_res_w
    $error("converter_ref_and_input_control: RES_W must be 10");
  end

  ref_sel_t         ref_r;
  logic [4:0]       in_sel_r;
  logic [2:0]       flags_r;
  logic [2:0]       mask_r;
  logic             dac_en_r;
  logic             neg_dac_r;
  logic             start_r;
  logic [7:0]       rdata_nxt;
  logic [RES_W-1:0] smp_m_r, smp_r;
  logic [7:0]       pos_m_r, pos_r, neg_m_r, neg_r;
  logic             cmp_prev_r;
  logic             busy;
  logic [4:0]       src;
  logic [7:0]       level;
  logic             dac_upd, cmp_w;
  adc_res_t         res;
  adc_req_t         req;
  logic [2:0]       flag_clr;
  logic [2:0]       flag_set;
  logic [2:0]       flags_nxt;

  function automatic logic wr_at(input logic [3:0] a, input logic [3:0] off,
                                 input logic w);
    wr_at = w && (a == off);
  endfunction

  // set wins over a write-one clear in the same cycle
  function automatic logic [2:0] flags_nxt_f(input logic [2:0] f, input logic [2:0] clr,
                                             input logic [2:0] set);
    flags_nxt_f = (f & ~clr) | set;
  endfunction

  // two-stage synchronisers for analog-side levels
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      smp_m_r <= '0;
      smp_r   <= '0;
      pos_m_r <= 8'h00;
      pos_r   <= 8'h00;
      neg_m_r <= 8'h00;
      neg_r   <= 8'h00;
    end else if (clk_en_i) begin
      smp_m_r <= adc_sample_i;
      smp_r   <= smp_m_r;
      pos_m_r <= cmp_pos_level_i;
      pos_r   <= pos_m_r;
      neg_m_r <= cmp_neg_pin_level_i;
      neg_r   <= neg_m_r;
    end
  end

  // reference select register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) ref_r <= '0;
    else if (clk_en_i && wr_at(addr_i, `OFF_REF_SEL, wr_i)) begin
      ref_r.adc_ref <= wdata_i[`REF_ADC_MSB:`REF_ADC_LSB];
      ref_r.dac_ref <= wdata_i[`REF_DAC_MSB:`REF_DAC_LSB];
    end
  end

  // input select register; applied by the sequencer between conversions
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) in_sel_r <= 5'h00;
    else if (clk_en_i && wr_at(addr_i, `OFF_IN_SEL, wr_i)) in_sel_r <= wdata_i[4:0];
  end

  // start strobe from command write
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) start_r <= 1'b0;
    else if (clk_en_i)
      start_r <= wr_at(addr_i, `OFF_COMMAND, wr_i) && wdata_i[`CMD_START_BIT];
  end

  // dac and comparator control
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dac_en_r  <= 1'b0;
      neg_dac_r <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_at(addr_i, `OFF_DAC_CTRL, wr_i)) dac_en_r <= wdata_i[`DAC_ENABLE_BIT];
      if (wr_at(addr_i, `OFF_CMP_CTRL, wr_i)) neg_dac_r <= wdata_i[`CMP_NEG_DAC_BIT];
    end
  end

  assign req = '{source: in_sel_r, start: start_r};

  adc_sequencer #(
    .CONV_CYCLES (CONV_CYCLES),
    .RES_W       (RES_W)
  ) u_seq (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .req_i     (req),
    .sample_i  (smp_r),
    .busy_o    (busy),
    .source_o  (src),
    .res_o     (res)
  );

  dac_comparator u_dac (
    .sys_clk_i       (sys_clk_i),
    .rst_n_i         (rst_n_i),
    .clk_en_i        (clk_en_i),
    .dac_en_i        (dac_en_r),
    .data_wr_i       (wr_at(addr_i, `OFF_DAC_DATA, wr_i)),
    .data_i          (wdata_i),
    .neg_dac_i       (neg_dac_r),
    .neg_pin_level_i (neg_r),
    .pos_level_i     (pos_r),
    .level_o         (level),
    .update_o        (dac_upd),
    .cmp_o           (cmp_w)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) cmp_prev_r <= 1'b0;
    else if (clk_en_i) cmp_prev_r <= cmp_w;
  end

  // sticky flags: set wins over write-one clear
  assign flag_clr  = wr_at(addr_i, `OFF_FLAGS, wr_i) ? wdata_i[2:0] : 3'h0;
  assign flag_set  = {cmp_w != cmp_prev_r, dac_upd, res.valid};
  assign flags_nxt = flags_nxt_f(flags_r, flag_clr, flag_set);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) flags_r <= 3'h0;
    else if (clk_en_i) flags_r <= flags_nxt;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) mask_r <= 3'h0;
    else if (clk_en_i && wr_at(addr_i, `OFF_IRQ_MASK, wr_i)) mask_r <= wdata_i[2:0];
  end

  // read mux
  always_comb begin
    case (addr_i)
      `OFF_REF_SEL:   rdata_nxt = {1'b0, ref_r.adc_ref, 1'b0, ref_r.dac_ref};
      `OFF_IN_SEL:    rdata_nxt = {3'h0, in_sel_r};
      `OFF_COMMAND:   rdata_nxt = {7'h00, busy};
      `OFF_FLAGS:     rdata_nxt = {5'h00, flags_r};
      `OFF_IRQ_MASK:  rdata_nxt = {5'h00, mask_r};
      `OFF_RESULT_LO: rdata_nxt = res.value[7:0];
      `OFF_RESULT_HI: rdata_nxt = {6'h00, res.value[9:8]};
      `OFF_DAC_CTRL:  rdata_nxt = {7'h00, dac_en_r};
      `OFF_DAC_DATA:  rdata_nxt = level;
      `OFF_CMP_CTRL:  rdata_nxt = {7'h00, neg_dac_r};
      `OFF_STATUS:    rdata_nxt = {6'h00, cmp_w, busy};
      default:        rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) rdata_o <= 8'h00;
    else if (clk_en_i) rdata_o <= rd_i ? rdata_nxt : 8'h00;
  end

  // registered outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      adc_ref_sel_o <= 3'h0;
      dac_ref_sel_o <= 3'h0;
      adc_source_o  <= 5'h00;
      adc_busy_o    <= 1'b0;
      dac_level_o   <= 8'h00;
      cmp_o         <= 1'b0;
      irq_o         <= 1'b0;
    end else if (clk_en_i) begin
      adc_ref_sel_o <= ref_r.adc_ref;
      dac_ref_sel_o <= ref_r.dac_ref;
      adc_source_o  <= src;
      adc_busy_o    <= busy;
      dac_level_o   <= level;
      cmp_o         <= cmp_w;
      irq_o         <= |(flags_nxt & mask_r);
    end
  end

  sequence s_start;
    clk_en_i && wr_i && addr_i == `OFF_COMMAND && wdata_i[`CMD_START_BIT] && !busy;
  endsequence

  property p_start_busy;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_start ##1 clk_en_i |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not begin conversion");

  property p_flag_set;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && res.valid |=> flags_r[`FLAG_RESULT_READY_FLAG_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("result ready flag not set");

  property p_flag_sticky;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      flags_r[0] && !(wr_i && addr_i == `OFF_FLAGS && wdata_i[0]) |=> flags_r[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

  property p_res_ready;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(flags_r[0]) |-> res.value == $past(smp_r, 2);
  endproperty
  a_res_ready: assert property (p_res_ready) else $error("result not present with flag");

  property p_ref_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_i && addr_i == `OFF_REF_SEL && clk_en_i |=> rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0;
  endproperty
  a_ref_zero: assert property (p_ref_zero) else $error("reserved ref bits nonzero");

  property p_insel_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_i && addr_i == `OFF_IN_SEL && clk_en_i |=> rdata_o[7:5] == 3'h0;
  endproperty
  a_insel_zero: assert property (p_insel_zero) else $error("input select upper bits nonzero");

  property p_dac_write;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && dac_en_r && wr_i && addr_i == `OFF_DAC_DATA |=> level == $past(wdata_i);
  endproperty
  a_dac_write: assert property (p_dac_write) else $error("dac write not applied");

  property p_ref_write;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && wr_i && addr_i == `OFF_REF_SEL
        |=> ref_r.adc_ref == $past(wdata_i[6:4]) && ref_r.dac_ref == $past(wdata_i[2:0]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference fields not stored");

  property p_flag_clear;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && wr_i && addr_i == `OFF_FLAGS && wdata_i[0] && !res.valid |=> !flags_r[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("ready flag not cleared");

  property p_irq_level;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i |=> irq_o == (|(flags_r & $past(mask_r)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_rd_idle;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

  property p_unmapped_rd;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && rd_i && addr_i > `OFF_STATUS |=> rdata_o == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read nonzero");

  property p_insel_write;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && wr_i && addr_i == `OFF_IN_SEL |=> in_sel_r == $past(wdata_i[4:0]);
  endproperty
  a_insel_write: assert property (p_insel_write) else $error("input select not stored");

  property p_src_out;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i |=> adc_source_o == $past(src);
  endproperty
  a_src_out: assert property (p_src_out) else $error("source output wrong");

  property p_level_out;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i |=> dac_level_o == $past(level);
  endproperty
  a_level_out: assert property (p_level_out) else $error("dac level output wrong");

  property p_dac_off;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && !dac_en_r && wr_i && addr_i == `OFF_DAC_DATA |=> $stable(level);
  endproperty
  a_dac_off: assert property (p_dac_off) else $error("disabled dac level moved");

  property p_cmp_dac;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && neg_dac_r |=> cmp_w == ($past(pos_r) > $past(level));
  endproperty
  a_cmp_dac: assert property (p_cmp_dac) else $error("compare against dac wrong");

  property p_cmp_pin;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && !neg_dac_r |=> cmp_w == ($past(pos_r) > $past(neg_r));
  endproperty
  a_cmp_pin: assert property (p_cmp_pin) else $error("compare against pin wrong");

endmodule

/* File: dv/analog_partner.sv */
// behavioural analog converter core feeding the digitised sample
`timescale 1ns/10ps
module analog_partner (
  // state of the digital side
  input  wire logic [4:0] source_i,
  input  wire logic [7:0] level_i,
  // digitised sample
  output logic [9:0]      sample_o
);
  // dac source shows the dac level, others a source-coded value
  assign sample_o = (source_i == 5'h1c) ? {2'h0, level_i} : {source_i, 5'h0a};
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the converter reference and input control
`timescale 1ns/10ps
`include "conv_ctrl_regs.svh"
module tb_top;
  logic       sys_clk_i;
  logic       rst_n_i;
  logic       clk_en_i;
  logic       wr_i;
  logic       rd_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic [7:0] cmp_pos_level_i;
  logic [7:0] cmp_neg_pin_level_i;
  logic [7:0] dac_level_o;
  logic [9:0] adc_sample_i;
  logic [2:0] adc_ref_sel_o;
  logic [2:0] dac_ref_sel_o;
  logic [4:0] adc_source_o;
  logic       adc_busy_o;
  logic       cmp_o;
  logic       irq_o;
  int         num_errors;
  int         samples_checked;
  int         seed;
  int         i;
  logic [7:0] d;
  logic [7:0] v;
  logic [7:0] lvl;
  logic [7:0] npin;
  logic [4:0] src;
  logic [4:0] codes [5] = '{5'h0b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};

  converter_ref_and_input_control u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .adc_sample_i(adc_sample_i), .cmp_pos_level_i(cmp_pos_level_i),
    .cmp_neg_pin_level_i(cmp_neg_pin_level_i), .adc_ref_sel_o(adc_ref_sel_o),
    .dac_ref_sel_o(dac_ref_sel_o), .adc_source_o(adc_source_o), .adc_busy_o(adc_busy_o),
    .dac_level_o(dac_level_o), .cmp_o(cmp_o), .irq_o(irq_o)
  );

  analog_partner u_analog (
    .source_i(adc_source_o), .level_i(dac_level_o), .sample_o(adc_sample_i)
  );

  function automatic logic [9:0] conv_exp(input logic [4:0] s, input logic [7:0] l);
    return (s == `IN_SEL_DAC) ? {2'h0, l} : {s, 5'h0a};
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge sys_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= x;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge sys_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1;
    x = rdata_o;
  endtask

  // poll the ready flag under a bound, then fetch the result pair
  task automatic wait_res(input logic [9:0] exp);
    logic [7:0] f;
    f = 8'h00;
    for (int k = 0; k < 80 && f[0] !== 1'b1; k++) rd(`OFF_FLAGS, f);
    chk(f[0], 1'b1);
    if (f[0] !== 1'b1) give_verdict();
    rd(`OFF_RESULT_LO, f);
    chk(f, exp[7:0]);
    rd(`OFF_RESULT_HI, f);
    chk(f, {6'h00, exp[9:8]});
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    seed = 32'h8b1c;
    num_errors = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    cmp_pos_level_i = 8'h00;
    cmp_neg_pin_level_i = 8'h00;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(`OFF_REF_SEL, d);
    chk(d, 8'h00);
    rd(`OFF_IN_SEL, d);
    chk(d, 8'h00);
    rd(4'hf, d);
    chk(d, 8'h00);
    $display("reset values test done");
    for (i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      v[6] = v[6] & ~(v[5] | v[4]);
      v[2] = v[2] & ~(v[1] | v[0]);
      if (i < 5) v = {1'b1, 3'(i), 1'b1, 3'(4 - i)};
      wr(`OFF_REF_SEL, v);
      rd(`OFF_REF_SEL, d);
      chk(d, v & 8'h77);
      chk(adc_ref_sel_o, v[6:4]);
      chk(dac_ref_sel_o, v[2:0]);
    end
    $display("reference select test done");
    wr(`OFF_DAC_CTRL, 8'h01);
    lvl = 8'($random(seed));
    wr(`OFF_DAC_DATA, lvl);
    rd(`OFF_FLAGS, d);
    chk(d[1], 1'b1);
    chk(dac_level_o, lvl);
    wr(`OFF_FLAGS, 8'h02);
    for (i = 0; i < 9; i++) begin
      src = (i < 5) ? codes[i] : codes[$unsigned($random(seed)) % 5];
      wr(`OFF_IN_SEL, {3'h7, src});
      rd(`OFF_IN_SEL, d);
      chk(d, {3'h0, src});
      wr(`OFF_COMMAND, 8'h01);
      wait_res(conv_exp(src, lvl));
      chk(adc_source_o, src);
      wr(`OFF_FLAGS, 8'h01);
    end
    $display("input select and conversion test done");
    wr(`OFF_IN_SEL, 8'h1e);
    wr(`OFF_COMMAND, 8'h01);
    wr(`OFF_IN_SEL, 8'h1f);
    chk(adc_source_o, 5'h1e);
    chk(adc_busy_o, 1'b1);
    // enable low mid conversion: the count must not advance
    clk_en_i <= 1'b0;
    repeat (40) @(posedge sys_clk_i);
    #1;
    chk(adc_busy_o, 1'b1);
    chk(adc_source_o, 5'h1e);
    clk_en_i <= 1'b1;
    wait_res(conv_exp(5'h1e, lvl));
    chk(adc_busy_o, 1'b0);
    chk(irq_o, 1'b0);
    wr(`OFF_IRQ_MASK, 8'h01);
    wr(`OFF_FLAGS, 8'h00);
    rd(`OFF_FLAGS, d);
    chk(d[0], 1'b1);
    chk(irq_o, 1'b1);
    wr(`OFF_FLAGS, 8'h01);
    rd(`OFF_FLAGS, d);
    chk(d[0], 1'b0);
    chk(irq_o, 1'b0);
    wr(`OFF_IRQ_MASK, 8'h00);
    wr(`OFF_COMMAND, 8'h01);
    wait_res(conv_exp(5'h1f, lvl));
    $display("mid-conversion and flag test done");
    wr(`OFF_FLAGS, 8'h07);
    wr(`OFF_DAC_CTRL, 8'h00);
    wr(`OFF_DAC_DATA, ~lvl);
    rd(`OFF_FLAGS, d);
    chk(d[1], 1'b0);
    chk(dac_level_o, lvl);
    wr(`OFF_DAC_CTRL, 8'h01);
    for (i = 0; i < 10; i++) begin
      lvl = (i == 1) ? 8'hff : (i == 3) ? 8'h00 : 8'($random(seed));
      npin = 8'($random(seed));
      v = (i == 5) ? lvl : 8'($random(seed));
      wr(`OFF_CMP_CTRL, {7'h00, i[0]});
      wr(`OFF_DAC_DATA, lvl);
      cmp_pos_level_i     <= v;
      cmp_neg_pin_level_i <= npin;
      // fixed wait: two sync stages, compare flop, output flop
      repeat (5) @(posedge sys_clk_i);
      #1;
      chk(dac_level_o, lvl);
      chk(cmp_o, v > (i[0] ? lvl : npin));
      rd(`OFF_STATUS, d);
      chk(d[1], v > (i[0] ? lvl : npin));
    end
    $display("dac and comparator test done");
    give_verdict();
  end
endmodule
